// ===== verilog/sacs_sequencer.sv
// Channel sequencer, range check and AXI4-Lite register file for a 12-bit SAR converter.
// Function
// (RQ1) Eight pin inputs, each selectable for scan.
// (RQ2) Back-to-back channels, no idle cycles between.
// (RQ3) Autonomous scan or firmware-chosen next channel.
// (RQ4) Separate result buffer for every channel.
// (RQ5) Per-channel programmable sample time applied.
// (RQ6) Low/high window raises out-of-range interrupt.
// (RQ7) Range check on each result immediately.
// (RQ8) Conversion takes 18 clocks, clock under 14.5MHz.
// (RQ9) Reference select: supply, half, bandgap, external.
// (RQ10) Programmable sample-and-hold aperture extension.
// (RQ11) Temperature sensor selectable as extra channel.
// (RQ12) Unavailable in deep low-power states.
// (RQ13) Results are 12 bits into buffers.
// (RQ14) Strict comparison; flag sticky until cleared.
`timescale 1ns/100ps
`default_nettype none
module sacs_sequencer
	import sacs_pkg::*;
#(
	parameter int NUM_PINS = 8,
	parameter int RES_BITS = 12
)(
	input  wire logic                sys_clk,
	input  wire logic                sys_rst,
	input  wire logic [7:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [7:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	input  wire logic                lowPowerState,
	output logic                     adcClk,
	output logic [3:0]               adcChannel,
	output logic                     adcSample,
	output logic                     adcConvert,
	output logic [1:0]               adcRefSel,
	output logic [3:0]               adcAperture,
	input  wire logic [RES_BITS-1:0] adcData,
	output logic                     irq
);
	// ==========================================
	// Storage
	localparam int NCH = NUM_PINS + 1;      // Last channel is the temperature sensor.
	localparam int CW  = $clog2(NCH);
	logic [31:0]         ctrl;              // Enable, mode, reference and aperture.
	logic [NCH-1:0]      chanEn;            // Scan selection, one bit per channel.
	logic [31:0]         limits;            // Low window limit low half, high limit upper half.
	logic [1:0]          intStat;           // Sticky events.
	logic [1:0]          intMask;           // Interrupt enables.
	logic [7:0]          sampleTime [NCH];  // Sample length per channel in converter clocks.
	logic [RES_BITS-1:0] result [NCH];      // Result buffers.
	logic                fwPend;            // Firmware request waiting.
	logic [CW-1:0]       fwChan;            // Channel firmware asked for.
	sacs_state_e         state;             // Sequencer state.
	logic [CW-1:0]       curChan;           // Channel in conversion.
	logic [8:0]          phaseCnt;          // Converter clocks left in the phase.
	logic [7:0]          divCnt;            // System clocks within one converter clock.
	logic                tick;              // Converter clock falling edge.
	logic                run;               // Sequencer allowed to work.
	logic                convEnd;           // Last clock of a conversion.
	logic                wrTake;            // Write address and data taken.
	logic                rdTake;            // Read address taken.
	logic [31:0]         wMask;             // Byte-lane mask of the write.
	logic [CW-1:0]       nextChan;          // Next enabled channel after the current one.
	logic                oor;               // Current result outside the window.
	logic [RES_BITS-1:0] lowLim;
	logic [RES_BITS-1:0] highLim;

	assign lowLim  = limits[RES_BITS-1:0];
	assign highLim = limits[LIMIT_HI_LSB +: RES_BITS];
	assign run     = ctrl[CTRL_EN_BIT] && !lowPowerState; // RQ12
	assign wrTake  = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign rdTake  = s_axi_arvalid && !s_axi_rvalid;
	assign s_axi_awready = wrTake;
	assign s_axi_wready  = wrTake;
	assign s_axi_arready = !s_axi_rvalid;
	assign wMask   = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
	assign tick    = run && (divCnt == 8'(CONV_DIV - 1));
	assign convEnd = (state == ST_CONVERT) && tick && (phaseCnt == 9'h001);
	assign oor     = (adcData < lowLim) || (adcData > highLim); // RQ14
	assign irq     = |(intStat & intMask);

	// Round-robin search for the next selected channel, wrapping past the temperature channel.
	function automatic logic [CW-1:0] findNext(input logic [NCH-1:0] en, input logic [CW-1:0] cur);
		logic [CW-1:0] pick;
		int            idx;
		pick = cur;
		for (int k = NCH; k >= 1; k--)
		begin
			idx = (int'(cur) + k) % NCH;
			if (en[idx])
				pick = CW'(idx);
		end
		return pick;
	endfunction
	assign nextChan = findNext(chanEn, curChan); // RQ1

	// ==========================================
	// Converter clock
	// Divide the system clock so the converter clock stays below its ceiling; stopped when unavailable.
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst || !run)
		begin
			divCnt <= 8'h00;
			adcClk <= 1'b0;
		end
		else
		begin
			divCnt <= tick ? 8'h00 : divCnt + 8'h01; // RQ8
			adcClk <= (divCnt >= 8'(CONV_DIV / 2 - 1)) && !tick;
		end
	end

	// ==========================================
	// Sequencer state machine
	// The next channel's sampling starts on the very edge that ends a conversion, so the
	// aggregate rate does not depend on how many channels are scanned.
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst || !run)
		begin
			state    <= ST_IDLE; // RQ12
			curChan  <= '0;
			phaseCnt <= 9'h000;
		end
		else
		begin
			case (state)
				ST_IDLE:
				begin
					// Leave idle only on a converter clock edge, so the first sample phase is made of
					// whole converter clocks, the same as in a back-to-back scan.
					if (!tick)
						state <= ST_IDLE;
					else if (ctrl[CTRL_FW_BIT])
					begin
						// Firmware selects the channel.
						if (fwPend)
						begin
							state    <= ST_SAMPLE; // RQ3
							curChan  <= fwChan;
							phaseCnt <= 9'(sampleTime[fwChan]) + 9'(ctrl[CTRL_APER_LSB +: 4]) + 9'h001;
						end
					end
					else if (|chanEn)
					begin
						// Autonomous scan begins at the first selected channel.
						state    <= ST_SAMPLE;
						curChan  <= findNext(chanEn, CW'(NCH - 1));
						phaseCnt <= 9'(sampleTime[findNext(chanEn, CW'(NCH - 1))])
							+ 9'(ctrl[CTRL_APER_LSB +: 4]) + 9'h001;
					end
				end
				ST_SAMPLE:
				begin
					// Hold the input open for the channel's own sample time plus aperture plus one converter clock.
					if (tick)
					begin
						if (phaseCnt == 9'h001)
						begin
							state    <= ST_CONVERT;
							phaseCnt <= 9'(CONV_CLOCKS); // RQ8
						end
						else
							phaseCnt <= phaseCnt - 9'h001; // RQ5 RQ10
					end
				end
				ST_CONVERT:
				begin
					if (tick && phaseCnt != 9'h001)
						phaseCnt <= phaseCnt - 9'h001;
					else if (convEnd)
					begin
						if (ctrl[CTRL_FW_BIT])
						begin
							if (fwPend)
							begin
								state    <= ST_SAMPLE; // RQ2
								curChan  <= fwChan;
								phaseCnt <= 9'(sampleTime[fwChan]) + 9'(ctrl[CTRL_APER_LSB +: 4]) + 9'h001;
							end
							else
								state <= ST_IDLE;
						end
						else if (|chanEn)
						begin
							state    <= ST_SAMPLE; // RQ2
							curChan  <= nextChan;
							phaseCnt <= 9'(sampleTime[nextChan]) + 9'(ctrl[CTRL_APER_LSB +: 4]) + 9'h001;
						end
						else
							state <= ST_IDLE;
					end
				end
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// ==========================================
	// Converter-facing outputs
	// Registered so the analog mux and hold switch see clean levels.
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			adcChannel  <= 4'h0;
			adcSample   <= 1'b0;
			adcConvert  <= 1'b0;
			adcRefSel   <= 2'b00;
			adcAperture <= 4'h0;
		end
		else
		begin
			adcChannel  <= 4'(curChan); // RQ11
			adcSample   <= (state == ST_SAMPLE);
			adcConvert  <= (state == ST_CONVERT);
			adcRefSel   <= ctrl[CTRL_REF_LSB +: 2]; // RQ9
			adcAperture <= ctrl[CTRL_APER_LSB +: 4]; // RQ10
		end
	end

	// ==========================================
	// Result buffers
	// Each channel keeps its last result so firmware can read a whole scan at once.
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < NCH; i++)
				result[i] <= '0;
		end
		else if (convEnd)
			result[curChan] <= adcData; // RQ4 RQ13
	end

	// ==========================================
	// Firmware request
	// A new request written in the cycle the old one is taken still stands.
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			fwPend <= 1'b0;
			fwChan <= '0;
		end
		else if (wrTake && s_axi_awaddr == FW_NEXT_OFF && s_axi_wstrb[0])
		begin
			fwPend <= (32'(s_axi_wdata[3:0]) < NCH); // RQ3
			fwChan <= CW'(s_axi_wdata[3:0]);
		end
		else if ((state == ST_IDLE && tick && ctrl[CTRL_FW_BIT]) || (convEnd && ctrl[CTRL_FW_BIT]))
			fwPend <= 1'b0;
	end

	// ==========================================
	// Interrupt status
	// The range event is raised per result, the scan event once per scan; a set beats a write-one-to-clear.
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			intStat <= 2'b00;
		else
		begin
			logic [1:0] clr;
			logic [1:0] set;
			clr = (wrTake && s_axi_awaddr == INT_STAT_OFF) ? (s_axi_wdata[1:0] & wMask[1:0]) : 2'b00;
			set = 2'b00;
			set[INT_OOR_BIT]  = convEnd && oor; // RQ6 RQ7
			set[INT_SCAN_BIT] = convEnd && !ctrl[CTRL_FW_BIT] && (nextChan <= curChan);
			intStat <= (intStat & ~clr) | set; // RQ14
		end
	end

	// ==========================================
	// Configuration registers
	// Byte strobes select the lanes that change.
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			ctrl    <= CTRL_RST;
			chanEn  <= NCH'(CHAN_EN_RST);
			limits  <= LIMIT_RST;
			intMask <= 2'b00;
			for (int i = 0; i < NCH; i++)
				sampleTime[i] <= SAMPLE_RST;
		end
		else if (wrTake)
		begin
			case (s_axi_awaddr)
				CTRL_OFF:     ctrl    <= (ctrl & ~wMask) | (s_axi_wdata & wMask);
				CHAN_EN_OFF:  chanEn  <= (chanEn & ~wMask[NCH-1:0]) | (s_axi_wdata[NCH-1:0] & wMask[NCH-1:0]); // RQ1
				LIMIT_OFF:    limits  <= (limits & ~wMask) | (s_axi_wdata & wMask); // RQ6
				INT_MASK_OFF: intMask <= (intMask & ~wMask[1:0]) | (s_axi_wdata[1:0] & wMask[1:0]);
				default:
				begin
					for (int i = 0; i < NCH; i++)
						if (s_axi_awaddr == SAMPLE_OFF + 8'(4 * i) && s_axi_wstrb[0])
							sampleTime[i] <= s_axi_wdata[7:0]; // RQ5
				end
			endcase
		end
	end

	// ==========================================
	// Write response
	// Unmapped addresses complete with a slave error and change nothing.
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end
		else if (wrTake)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (s_axi_awaddr[1:0] == 2'b00 && (s_axi_awaddr <= LIMIT_OFF
				|| (s_axi_awaddr >= SAMPLE_OFF && s_axi_awaddr < SAMPLE_OFF + 8'(4 * NCH))))
				? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// ==========================================
	// Read channel
	// Data is registered, so the answer follows the address by one cycle.
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end
		else if (rdTake)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= RESP_OKAY;
			s_axi_rdata  <= 32'h0000_0000;
			case (s_axi_araddr)
				CTRL_OFF:     s_axi_rdata <= ctrl;
				CHAN_EN_OFF:  s_axi_rdata <= 32'(chanEn);
				FW_NEXT_OFF:  s_axi_rdata <= {27'h0, fwPend, 4'(fwChan)};
				STATUS_OFF:   s_axi_rdata <= {24'h0, 4'(curChan), 1'b0, lowPowerState, state != ST_IDLE, run};
				INT_STAT_OFF: s_axi_rdata <= {30'h0, intStat};
				INT_MASK_OFF: s_axi_rdata <= {30'h0, intMask};
				LIMIT_OFF:    s_axi_rdata <= limits;
				default:
				begin
					s_axi_rresp <= RESP_SLVERR;
					for (int i = 0; i < NCH; i++)
					begin
						if (s_axi_araddr == SAMPLE_OFF + 8'(4 * i))
						begin
							s_axi_rdata <= {24'h0, sampleTime[i]};
							s_axi_rresp <= RESP_OKAY;
						end
						if (s_axi_araddr == RESULT_OFF + 8'(4 * i))
						begin
							s_axi_rdata <= 32'(result[i]); // RQ4
							s_axi_rresp <= RESP_OKAY;
						end
					end
				end
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule
`default_nettype wire

// ===== verilog/sacs_pkg.sv
// Package of register map, field layout and timing constants for the converter sequencer.
`default_nettype none
package sacs_pkg;
	// ==========================================
	// Register byte offsets
	localparam logic [7:0] CTRL_OFF     = 8'h00;
	localparam logic [7:0] CHAN_EN_OFF  = 8'h04;
	localparam logic [7:0] FW_NEXT_OFF  = 8'h08;
	localparam logic [7:0] STATUS_OFF   = 8'h0c;
	localparam logic [7:0] INT_STAT_OFF = 8'h10;
	localparam logic [7:0] INT_MASK_OFF = 8'h14;
	localparam logic [7:0] LIMIT_OFF    = 8'h18;
	localparam logic [7:0] SAMPLE_OFF   = 8'h20;
	localparam logic [7:0] RESULT_OFF   = 8'h60;
	// ==========================================
	// Field positions
	localparam int CTRL_EN_BIT   = 0;
	localparam int CTRL_FW_BIT   = 1;
	localparam int CTRL_REF_LSB  = 2;
	localparam int CTRL_APER_LSB = 4;
	localparam int LIMIT_HI_LSB  = 16;
	localparam int INT_OOR_BIT   = 0;
	localparam int INT_SCAN_BIT  = 1;
	localparam int STAT_CH_LSB   = 4;
	// ==========================================
	// Reset values
	localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
	localparam logic [31:0] CHAN_EN_RST = 32'h0000_0000;
	localparam logic [31:0] LIMIT_RST   = 32'h0fff_0000;
	localparam logic [7:0]  SAMPLE_RST  = 8'h03;
	// ==========================================
	// Timing: converter clock is derived from the 50 MHz system clock.
	localparam int SYS_CLK_KHZ      = 50000;
	localparam int CONV_CLK_MAX_KHZ = 14500;
	localparam int CONV_DIV         = (SYS_CLK_KHZ + CONV_CLK_MAX_KHZ - 1) / CONV_CLK_MAX_KHZ;
	localparam int CONV_CLOCKS      = 18;
	// ==========================================
	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// Sequencer states, one-hot.
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b001,
		ST_SAMPLE  = 3'b010,
		ST_CONVERT = 3'b100
	} sacs_state_e;
endpackage
`default_nettype wire

// ===== verif/sacs_conv_model.sv
// Behavioural converter core and analog inputs facing the sequencer.
`timescale 1ns/100ps
`default_nettype none
module sacs_conv_model (
	input  wire logic        sys_clk,
	input  wire logic [3:0]  adcChannel,
	input  wire logic        adcSample,
	input  wire logic        adcConvert,
	input  wire logic [11:0] pinLevel [0:8],
	output logic      [11:0] adcData
);
	logic [3:0]  heldCh = 4'h0;    // Channel caught by the hold capacitor.
	logic [11:0] dataReg = 12'h5a5; // Value presented to the sequencer.
	assign adcData = dataReg;
	// The channel is followed while sampling and held after it, so a late channel change cannot leak in.
	// Outside a conversion the data toggles every cycle, so an early latch shows.
	always @(posedge sys_clk)
	begin
		if (adcSample)
			heldCh <= adcChannel;
		if (adcConvert)
			dataReg <= pinLevel[heldCh];
		else
			dataReg <= ~dataReg;
	end
endmodule
`default_nettype wire

// ===== verif/sacs_sequencer_assertions.sv
// Port-level checker for the converter sequencer.
`timescale 1ns/100ps
`default_nettype none
module sacs_sequencer_chk
	import sacs_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        sys_rst,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        lowPowerState,
	input wire logic        adcClk,
	input wire logic [3:0]  adcChannel,
	input wire logic        adcSample,
	input wire logic        adcConvert,
	input wire logic [1:0]  adcRefSel,
	input wire logic [3:0]  adcAperture
);
	localparam int CONV_MIN = CONV_CLOCKS * CONV_DIV;
	logic [7:0] convLen; // Cycles the convert phase has lasted.
	logic [2:0] lpHist;  // Recent low-power levels; an abort is no short conversion.
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// Helper counters for the long phases.
	always_ff @(posedge sys_clk)
	begin
		convLen <= (sys_rst || !adcConvert) ? 8'h00 : convLen + 8'h01;
		lpHist  <= sys_rst ? 3'h0 : {lpHist[1:0], lowPowerState};
	end
	sequence ctrlWrite;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_awaddr == CTRL_OFF && s_axi_wstrb[0];
	endsequence
	sequence cleanEnd;
		!lowPowerState && lpHist == 3'h0;
	endsequence
	clk_rate_a: assert property ($rose(adcClk) |=> (!$rose(adcClk))[*3])
		else $error("converter clock too fast");
	conv_length_a: assert property ($fell(adcConvert) ##0 cleanEnd |-> convLen >= CONV_MIN)
		else $error("conversion too short");
	sample_convert_a: assert property ($fell(adcSample) ##0 cleanEnd |-> adcConvert)
		else $error("gap after sampling");
	ref_aperture_a: assert property (ctrlWrite |-> ##2 adcRefSel == $past(s_axi_wdata[3:2], 2)
		&& adcAperture == $past(s_axi_wdata[7:4], 2))
		else $error("reference or aperture not applied");
	chan_stable_a: assert property (adcSample && $past(adcSample) |-> $stable(adcChannel))
		else $error("channel moved while sampling");
	chan_range_a: assert property (adcChannel <= 4'h8)
		else $error("channel out of range");
	low_power_a: assert property (lowPowerState[*3] |-> !adcClk && !adcSample && !adcConvert)
		else $error("converter active in low power");
	write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid |=> s_axi_bvalid)
		else $error("write response late");
	read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
endmodule
bind sacs_sequencer sacs_sequencer_chk chk_u (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .lowPowerState(lowPowerState),
	.adcClk(adcClk), .adcChannel(adcChannel), .adcSample(adcSample), .adcConvert(adcConvert),
	.adcRefSel(adcRefSel), .adcAperture(adcAperture)
);
`default_nettype wire

// ===== verif/sacs_sequencer_tb.sv
// Self-checking bench: register bus tasks and sequencer scenarios.
`timescale 1ns/100ps
`default_nettype none
module sacs_sequencer_tb
	import sacs_pkg::*;
;
	logic        sys_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [7:0]  awAddr = 8'h00;
	logic [7:0]  arAddr = 8'h00;
	logic [31:0] wData = 32'h0;
	logic [3:0]  wStrb = 4'hf;
	logic        awValid = 1'b0;
	logic        wValid = 1'b0;
	logic        bReady = 1'b0;
	logic        arValid = 1'b0;
	logic        rReady = 1'b0;
	logic        lowPower = 1'b0;
	logic        awReady, wReady, bValid, arReady, rValid, adcClk, adcSample, adcConvert, irq;
	logic [1:0]  bResp, rResp, adcRefSel, wrResp;
	logic [31:0] rData;
	logic [3:0]  adcChannel, adcAperture, sampCh, nextCh;
	logic [11:0] adcData;
	logic [11:0] pinLevel [0:8] = '{12'h100, 12'h800, 12'h234, 12'h0ff, 12'h801, 12'hfff, 12'h400, 12'h400, 12'h456};
	logic [3:0]  oorCh [0:3] = '{4'h0, 4'h1, 4'h3, 4'h4}; // Two limit edges, then one below and one above.
	logic        lastConv, prevConv, convBefore;
	int          sampLen, waitCnt, miscompares, checksDone;
	always #10 sys_clk = ~sys_clk;
	sacs_sequencer dut_u (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
		.s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
		.s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
		.s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .lowPowerState(lowPower),
		.adcClk(adcClk), .adcChannel(adcChannel), .adcSample(adcSample), .adcConvert(adcConvert),
		.adcRefSel(adcRefSel), .adcAperture(adcAperture), .adcData(adcData), .irq(irq)
	);
	sacs_conv_model model_u (
		.sys_clk(sys_clk), .adcChannel(adcChannel), .adcSample(adcSample), .adcConvert(adcConvert),
		.pinLevel(pinLevel), .adcData(adcData)
	);
	task automatic reportAndStop;
		$display("Comparisons %0d, mismatches %0d", checksDone, miscompares);
		if (miscompares == 0 && checksDone > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One clock edge; values read here are those sampled by the design at that edge.
	task automatic tick;
		@(posedge sys_clk);
		prevConv = lastConv;
		lastConv = adcConvert;
		waitCnt++;
		if (waitCnt > 3000)
		begin
			miscompares++;
			reportAndStop();
		end
	endtask
	// Address and data are offered together and each dropped once taken.
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] v);
		waitCnt = 0;
		tick();
		awAddr <= a;
		wData <= v;
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		do tick(); while (awReady !== 1'b1);
		awValid <= 1'b0;
		wValid <= 1'b0;
		do tick(); while (bValid !== 1'b1);
		wrResp = bResp;
		bReady <= 1'b0;
	endtask
	task automatic expectRead(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
		waitCnt = 0;
		tick();
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		do tick(); while (arReady !== 1'b1);
		arValid <= 1'b0;
		do tick(); while (rValid !== 1'b1);
		rReady <= 1'b0;
		check(rData, v);
		check(32'(rResp), 32'(r));
	endtask
	// Catches the next sampling phase: its channel and length in cycles.
	task automatic waitSample;
		waitCnt = 0;
		do tick(); while (adcSample !== 1'b0);
		do tick(); while (adcSample !== 1'b1);
		sampCh = adcChannel;
		convBefore = prevConv;
		sampLen = 0;
		do
		begin
			tick();
			sampLen++;
		end
		while (adcSample === 1'b1);
	endtask
	task automatic convertOne(input logic [3:0] ch);
		axiWrite(FW_NEXT_OFF, 32'(ch));
		waitSample();
		check(32'(sampCh), 32'(ch));
		do tick(); while (adcConvert !== 1'b1);
		do tick(); while (adcConvert === 1'b1);
		tick();
	endtask
	initial
	begin
		repeat (4) @(posedge sys_clk);
		sys_rst <= 1'b0;
		expectRead(CTRL_OFF, CTRL_RST, RESP_OKAY);
		expectRead(LIMIT_OFF, LIMIT_RST, RESP_OKAY);
		expectRead(SAMPLE_OFF + 8'h08, 32'(SAMPLE_RST), RESP_OKAY);
		expectRead(8'hfc, 32'h0, RESP_SLVERR);
		axiWrite(8'hfc, 32'h1);
		check(32'(wrResp), 32'(RESP_SLVERR));
		// Firmware-chosen channel 2: short sample, bandgap reference, one aperture tick.
		axiWrite(SAMPLE_OFF + 8'h08, 32'h1);
		axiWrite(LIMIT_OFF, 32'h0800_0100);
		axiWrite(INT_MASK_OFF, 32'h1);
		axiWrite(CTRL_OFF, 32'h1b);
		convertOne(4'h2);
		check(32'(sampLen), 32'd12);
		check(32'(adcRefSel), 32'h2);
		expectRead(RESULT_OFF + 8'h08, 32'h234, RESP_OKAY);
		// Window edges count as inside; the flag outlives its mask.
		for (int i = 0; i < 4; i++)
		begin
			convertOne(oorCh[i]);
			check(32'(irq), 32'(i / 2));
			if (i > 1)
			begin
				axiWrite(INT_MASK_OFF, 32'h0);
				tick();
				check(32'(irq), 32'h0);
				expectRead(INT_STAT_OFF, 32'h1, RESP_OKAY);
				axiWrite(INT_STAT_OFF, 32'h1);
				axiWrite(INT_MASK_OFF, 32'h1);
				expectRead(INT_STAT_OFF, 32'h0, RESP_OKAY);
			end
		end
		// Autonomous scan of channels 0, 5 and the temperature sensor.
		axiWrite(CTRL_OFF, 32'h0);
		axiWrite(CHAN_EN_OFF, 32'h121);
		axiWrite(CTRL_OFF, 32'h1);
		waitSample();
		for (int i = 0; i < 3; i++)
		begin
			nextCh = (sampCh == 4'h0) ? 4'h5 : (sampCh == 4'h5) ? 4'h8 : 4'h0;
			waitSample();
			check(32'(sampCh), 32'(nextCh));
			check(32'(convBefore), 32'h1);
			check(32'(sampLen), 32'd16);
			if (sampCh == 4'h8)
				check(32'(irq), 32'h1);
		end
		expectRead(INT_STAT_OFF, 32'h3, RESP_OKAY);
		expectRead(RESULT_OFF + 8'h14, 32'hfff, RESP_OKAY);
		expectRead(RESULT_OFF + 8'h20, 32'h456, RESP_OKAY);
		lowPower <= 1'b1;
		repeat (5) tick();
		check(32'({adcClk, adcSample, adcConvert}), 32'h0);
		reportAndStop();
	end
endmodule
`default_nettype wire
